/* logic/rtc_trigger_ctrl.sv */
`timescale 1ns/10ps
module rtc_trigger_ctrl
    import rtc_pkg::*;
#(
    parameter int unsigned CONV_CYC = CONV_CYCLES
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // trigger pins, asynchronous
    input  wire logic                   ext_trig_n_pin,
    input  wire logic                   panel_trig_pin,
    // configuration
    input  wire logic                   store_enable,
    input  wire logic                   oneshot_select,
    input  wire logic                   buf_size_write,
    input  wire logic [BUF_SIZE_W-1:0]  buf_size_in,
    input  wire logic                   mode_code_write,
    input  wire logic [MODE_CODE_W-1:0] mode_code_in,
    // conversion engine
    output logic                        conv_start,
    input  wire logic                   conv_done,
    // data store and completion
    output logic                        store_write,
    output logic                        complete_n,
    // status
    output logic                        oneshot_active,
    output logic                        ext_trig_selected,
    output logic [BUF_SIZE_W-1:0]       buf_size,
    output logic                        reading_busy
);

    // synchronised pins: bit 1 external (idle high), bit 0 panel
    logic [1:0] pins_sync;
    logic [1:0] pins_prev_reg;

    rtc_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({ext_trig_n_pin, panel_trig_pin}),
        .rst_val  (2'h2),
        .sync_out (pins_sync)
    );

    // state
    rtc_state_e                 state_reg;
    rtc_state_e                 state_next;
    logic                       oneshot_reg;
    logic                       oneshot_pend_reg;
    logic                       ext_sel_reg;
    logic                       running_reg;
    logic                       running_next;
    logic [BUF_SIZE_W-1:0]      buf_size_reg;
    logic [CONV_CNT_W-1:0]      tb_cnt_reg;
    logic [PULSE_CNT_W-1:0]     pulse_cnt_reg;
    logic                       conv_start_reg;
    logic                       store_write_reg;

    // edge detection on the synchronised levels
    wire ext_fall    = pins_prev_reg[1] & ~pins_sync[1];
    wire panel_press = ~pins_prev_reg[0] & pins_sync[0];
    wire ext_event   = ext_fall & ext_sel_reg;
    wire is_idle     = (state_reg == RTC_IDLE);
    wire tb_tick     = (tb_cnt_reg == CONV_CNT_W'(CONV_CYC - 1));
    wire done_evt    = (state_reg == RTC_BUSY) & conv_done;
    wire code_is_ext = (mode_code_in == BUS_TRIGGER_MODE_CODE);
    wire ext_sel_set = mode_code_write & code_is_ext & ~ext_sel_reg;

    // one-shot accepts either source, only while idle
    wire oneshot_go  = oneshot_reg & is_idle
                       & (panel_press | ext_event);
    // continuous: time base pacing, or back to back after ext trigger
    wire cont_go     = ~oneshot_reg & running_reg & is_idle
                       & (ext_sel_reg | tb_tick);
    wire start_go    = oneshot_go | cont_go;

    // edge history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_prev_reg <= 2'h2;
        end else begin
            pins_prev_reg <= pins_sync;
        end
    end

    // mode selection: store, then one-shot choice, then buffer size
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oneshot_pend_reg <= 1'b0;
            oneshot_reg      <= 1'b0;
            buf_size_reg     <= BUF_SIZE_RST;
        end else if (!store_enable) begin
            oneshot_pend_reg <= 1'b0;
            oneshot_reg      <= 1'b0;
        end else begin
            if (oneshot_select) begin
                oneshot_pend_reg <= 1'b1;
            end
            if (buf_size_write && oneshot_pend_reg) begin
                buf_size_reg     <= buf_size_in;
                oneshot_reg      <= 1'b1;
                oneshot_pend_reg <= 1'b0;
            end
        end
    end

    // external trigger mode from the bus mode code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_sel_reg <= EXT_SEL_RST;
        end else if (mode_code_write) begin
            ext_sel_reg <= code_is_ext;
        end
    end

    // continuous run flag
    always_comb begin
        running_next = running_reg;
        if (oneshot_reg || ext_sel_set) begin
            running_next = 1'b0;
        end else if (!ext_sel_reg) begin
            running_next = 1'b1;
        end else if (ext_fall) begin
            running_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            running_reg <= RUNNING_RST;
        end else begin
            running_reg <= running_next;
        end
    end

    // internal time base
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_reg <= '0;
        end else if (tb_tick) begin
            tb_cnt_reg <= '0;
        end else begin
            tb_cnt_reg <= tb_cnt_reg + 1'b1;
        end
    end

    // reading cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RTC_IDLE: begin
                if (start_go) begin
                    state_next = RTC_BUSY;
                end
            end
            RTC_BUSY: begin
                if (conv_done) begin
                    state_next = RTC_IDLE;
                end
            end
            default: begin
                state_next = RTC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= RTC_IDLE;
            conv_start_reg  <= 1'b0;
            store_write_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            conv_start_reg  <= start_go;
            store_write_reg <= done_evt & oneshot_reg;
        end
    end

    // completion pulse, low for a fixed width after each reading
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_reg <= '0;
        end else if (done_evt) begin
            pulse_cnt_reg <= PULSE_CNT_W'(COMPLETE_CYCLES);
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
    end

    // outputs
    assign conv_start        = conv_start_reg;
    assign store_write       = store_write_reg;
    assign complete_n        = (pulse_cnt_reg == '0);
    assign oneshot_active    = oneshot_reg;
    assign ext_trig_selected = ext_sel_reg;
    assign buf_size          = buf_size_reg;
    assign reading_busy      = (state_reg == RTC_BUSY);

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_accept;
        oneshot_reg && is_idle && panel_press;
    endsequence

    sequence s_reading;
        conv_start ##0 reading_busy;
    endsequence

    a_oneshot_panel_start: assert property (
        s_accept |=> s_reading)
        else $error("panel press in one-shot did not start a reading");

    a_oneshot_store_gate: assert property (
        oneshot_active |-> $past(store_enable))
        else $error("one-shot active without data store");

    a_store_off_exit: assert property (
        !store_enable |=> !oneshot_active)
        else $error("one-shot kept after store disabled");

    a_store_each_reading: assert property (
        done_evt && oneshot_reg |=> store_write && !complete_n)
        else $error("triggered reading not stored");

    a_ext_edge_ignored: assert property (
        oneshot_reg && is_idle && ext_fall && !ext_sel_reg && !panel_press
        |=> !reading_busy && !conv_start)
        else $error("external edge accepted without external mode");

    a_busy_ignores_edges: assert property (
        reading_busy && !conv_done |=> reading_busy && !conv_start)
        else $error("new reading started while busy");

    a_complete_pulse_low: assert property (
        done_evt |=> !complete_n [*8])
        else $error("completion pulse too short or missing");

    a_complete_width: assert property (
        $rose(complete_n) |-> $past(pulse_cnt_reg) == 8'h01)
        else $error("completion pulse ended early");

    a_pulse_after_done: assert property (
        $fell(complete_n) |-> $past(done_evt))
        else $error("completion pulse without finished conversion");

    a_cont_paced: assert property (
        !oneshot_reg && running_reg && !ext_sel_reg && is_idle && tb_tick
        |=> conv_start)
        else $error("time base tick did not start reading");

    a_cont_back_to_back: assert property (
        !oneshot_reg && running_reg && ext_sel_reg && is_idle
        |=> conv_start)
        else $error("continuous external run stalled");

endmodule

/* logic/rtc_pkg.sv */
// Overview of operation
// - After reset run continuous readings paced by the internal time base.
// - In one-shot mode each front panel trigger press while idle starts exactly one reading.
// - One-shot needs store enabled, then one-shot choice, then buffer size.
// - With store enabled and one-shot active, each reading is written to store.
// - External trigger counts only its falling edge.
// - With external triggering selected, a falling edge starts readings in both modes.
// - Continuous mode, once triggered, takes readings back to back.
// - One-shot mode takes one reading per event, then waits idle.
// - In one-shot mode panel button and, with external mode selected, external input both start readings.
// - Disabling the data store leaves one-shot and returns to continuous.
// - External edges ignored unless external mode selected, by bus mode code.
// - Each finished reading starts a negative-going completion pulse, or restarts one still in progress.
// - Continuous completion pulses follow each finished conversion at conversion rate when conversions finish more than COMPLETE_CYCLES clocks apart.
// - One-shot mode gives one completion pulse per accepted trigger; readings ending within COMPLETE_CYCLES clocks of each other share one pulse.
package rtc_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS     = 100;
    localparam int unsigned COMPLETE_PULSE_NS = 10000;
    localparam int unsigned COMPLETE_CYCLES   =
        (COMPLETE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_PERIOD_NS    = 1000000;
    localparam int unsigned CONV_CYCLES       = CONV_PERIOD_NS / CLK_PERIOD_NS;

    // widths and codes
    localparam int unsigned PULSE_CNT_W = 8;
    localparam int unsigned CONV_CNT_W  = 24;
    localparam int unsigned MODE_CODE_W = 4;
    localparam int unsigned BUF_SIZE_W  = 10;
    localparam logic [MODE_CODE_W-1:0] BUS_TRIGGER_MODE_CODE = 4'h7;

    // reset values
    localparam logic [BUF_SIZE_W-1:0] BUF_SIZE_RST = 10'h000;
    localparam logic                  EXT_SEL_RST  = 1'b0;
    localparam logic                  RUNNING_RST  = 1'b1;

    // reading cycle states
    typedef enum logic [1:0] {
        RTC_IDLE,
        RTC_BUSY
    } rtc_state_e;

endpackage

/* logic/rtc_sync2.sv */
`timescale 1ns/10ps
module rtc_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] rst_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // two flops; only the second reads the first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in ^ rst_val;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg ^ rst_val;

endmodule

/* tb/rtc_scanner_model.sv */
`timescale 1ns/10ps
module rtc_scanner_model (
    // clock
    input  wire logic       clock,
    // scan control from the bench
    input  wire logic       scan_go,
    input  wire logic [3:0] scan_chans,
    // trigger link
    input  wire logic       complete_n,
    output logic            ext_trig_n_pin
);
    int chan;

    // one clean falling edge per channel, then wait for the meter
    initial begin
        ext_trig_n_pin = 1'b1; // idle high, pulled up when released
        forever begin
            @(posedge scan_go);
            for (chan = 0; chan < scan_chans; chan++) begin
                @(negedge clock);
                ext_trig_n_pin = 1'b0;
                repeat (3) @(negedge clock);
                ext_trig_n_pin = 1'b1;
                @(negedge complete_n);
                @(posedge complete_n);
            end
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
    import rtc_pkg::*;
    localparam int unsigned CONV_LAT = 10;
    // design pins
    logic                   clock, rst_n, ext_trig_n_pin, panel_trig_pin;
    logic                   store_enable, oneshot_select, buf_size_write;
    logic                   mode_code_write, conv_done, conv_start;
    logic                   store_write, complete_n, oneshot_active;
    logic                   ext_trig_selected, reading_busy, scan_go;
    logic [BUF_SIZE_W-1:0]  buf_size_in, buf_size;
    logic [MODE_CODE_W-1:0] mode_code_in;
    logic [3:0]             scan_chans;
    int                     error_cnt, num_checks, n_start, n_store, n_fall;
    int                     lo_run, last_lo, conv_cnt, s0, s1, s2;

    rtc_trigger_ctrl #(.CONV_CYC(20)) rtc_trigger_ctrl_inst (
        .clock(clock), .rst_n(rst_n), .ext_trig_n_pin(ext_trig_n_pin),
        .panel_trig_pin(panel_trig_pin), .store_enable(store_enable),
        .oneshot_select(oneshot_select), .buf_size_write(buf_size_write),
        .buf_size_in(buf_size_in), .mode_code_write(mode_code_write),
        .mode_code_in(mode_code_in), .conv_start(conv_start),
        .conv_done(conv_done), .store_write(store_write),
        .complete_n(complete_n), .oneshot_active(oneshot_active),
        .ext_trig_selected(ext_trig_selected), .buf_size(buf_size),
        .reading_busy(reading_busy));

    rtc_scanner_model rtc_scanner_model_inst (
        .clock(clock), .scan_go(scan_go), .scan_chans(scan_chans),
        .complete_n(complete_n), .ext_trig_n_pin(ext_trig_n_pin));

    // clock generator
    initial clock = 1'b0;
    always #50 clock = ~clock;

    // conversion engine and output counters, sampled mid-cycle
    always @(negedge clock) begin
        conv_done <= 1'b0;
        if (conv_cnt == 1) conv_done <= 1'b1;
        if (conv_cnt > 0) conv_cnt--;
        if (conv_start === 1'b1) begin
            conv_cnt = CONV_LAT;
            n_start++;
        end
        if (store_write === 1'b1) n_store++;
        if (complete_n === 1'b0) lo_run++;
        else if (lo_run != 0) begin
            last_lo = lo_run;
            lo_run = 0;
        end
        if (complete_n === 1'b0 && lo_run == 1) n_fall++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic snap();
        s0 = n_start;
        s1 = n_store;
        s2 = n_fall;
    endtask

    task automatic press();
        panel_trig_pin = 1'b1;
        tick(3);
        panel_trig_pin = 1'b0;
    endtask

    task automatic mode(input logic [MODE_CODE_W-1:0] code);
        mode_code_in = code;
        mode_code_write = 1'b1;
        tick(1);
        mode_code_write = 1'b0;
    endtask

    task automatic scan(input logic [3:0] n);
        scan_chans = n;
        scan_go = 1'b1;
        tick(1);
        scan_go = 1'b0;
    endtask

    task automatic t_cont();
        tick(1);
        chk(oneshot_active, 0);
        chk(ext_trig_selected, 0);
        chk(buf_size, 0);
        tick(100);
        chk(n_start >= 4, 1);
        chk(n_fall >= 1, 1);
        chk(n_store, 0);
    endtask

    task automatic t_config();
        oneshot_select = 1'b1;
        tick(1);
        oneshot_select = 1'b0;
        store_enable = 1'b1;
        tick(2);
        buf_size_in = 10'h2A5;
        buf_size_write = 1'b1;
        tick(1);
        buf_size_write = 1'b0;
        tick(1);
        chk(oneshot_active, 0);
        chk(buf_size, 0);
        oneshot_select = 1'b1;
        tick(1);
        oneshot_select = 1'b0;
        tick(1);
        buf_size_write = 1'b1;
        tick(1);
        buf_size_write = 1'b0;
        tick(1);
        chk(oneshot_active, 1);
        chk(buf_size, 10'h2A5);
        tick(130);
        s0 = n_start;
        tick(60);
        chk(n_start, s0);
    endtask

    task automatic t_panel();
        snap();
        press();
        chk(reading_busy, 1);
        tick(2);
        press();
        tick(130);
        chk(reading_busy, 0);
        chk(n_start, s0 + 1);
        chk(n_store, s1 + 1);
        chk(n_fall, s2 + 1);
        chk(last_lo, COMPLETE_CYCLES);
    endtask

    task automatic t_ext();
        mode(4'h3);
        tick(1);
        chk(ext_trig_selected, 0);
        snap();
        scan(1);
        tick(30);
        chk(n_start, s0);
        mode(BUS_TRIGGER_MODE_CODE);
        tick(1);
        chk(ext_trig_selected, 1);
        press();
        tick(130);
        chk(n_start, s0 + 1);
        snap();
        scan(3);
        tick(420);
        chk(n_start, s0 + 3);
        chk(n_store, s1 + 3);
        chk(n_fall, s2 + 3);
    endtask

    task automatic t_leave();
        store_enable = 1'b0;
        tick(1);
        chk(oneshot_active, 0);
        snap();
        scan(1);
        tick(60);
        chk(n_start >= s0 + 4, 1);
        chk(n_store, s1);
    endtask

    task print_verdict;
        $display("mismatches %0d of %0d checks", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clock);
        error_cnt++;
        print_verdict;
    end

    // reset, then scenarios in order
    initial begin
        {error_cnt, num_checks, n_start, n_store, n_fall} = '0;
        {lo_run, last_lo, conv_cnt} = '0;
        {rst_n, panel_trig_pin, store_enable, oneshot_select} = '0;
        {buf_size_write, mode_code_write, scan_go} = '0;
        buf_size_in = '0;
        mode_code_in = '0;
        scan_chans = '0;
        tick(2);
        rst_n = 1'b1;
        t_cont();
        t_config();
        t_panel();
        t_ext();
        t_leave();
        print_verdict;
    end
endmodule
